// File: core/cor_charge_option.v
// Charge option register bank with self-clearing action bits
`default_nettype none
`include "cor_charge_option_regs.vh"
module cor_charge_option #(
  parameter MS_CYCLES = `COR_MS_CYCLES
) (
  input  wire        clock,
  input  wire        reset,
  input  wire        i2c_mode,
  input  wire        wr_en,
  input  wire [7:0]  wr_addr,
  input  wire [15:0] wr_data,
  input  wire [7:0]  rd_addr,
  output reg  [15:0] rd_data,
  input  wire        adapter_plugged,
  input  wire        battery_low,
  input  wire        comparator_tripped,
  output wire        sense_resistor_ratio,
  output wire        battery_current_monitor_en,
  output wire        system_power_monitor_en,
  output wire        system_power_monitor_gain,
  output wire        comparator_reference_select,
  output wire        comparator_output_polarity,
  output wire [1:0]  comparator_deglitch_select,
  output wire        comparator_enable,
  output reg         power_path_latched_off,
  output wire        battery_switch_off,
  output wire        battery_pin_discharge,
  output reg         wakeup_charge_active,
  output wire [15:0] charge_option_two_q
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_WAKE = 2'h2;
  reg  [15:0] opt_one_q;
  reg  [15:0] opt_two_q;
  reg  [1:0]  wake_state_q;
  reg  [31:0] ms_div_q;
  reg  [5:0]  dis_ms_q;
  reg  [21:0] wake_ms_q;
  reg  [16:0] recov_ms_q;
  wire        ms_tick;
  wire [15:0] one_wr;
  wire [15:0] two_wr;
  wire        one_hit;
  wire        two_hit;
  wire        dis_done;
  wire        wake_done;
  wire        recov_done;

  // Merge byte or word write into current value
  function [15:0] merge;
    input        i2c;
    input [7:0]  addr;
    input [7:0]  lo_addr;
    input [15:0] cur;
    input [15:0] data;
    begin
      if (!i2c)
        merge = data;
      else if (addr == lo_addr)
        merge = {cur[15:8], data[7:0]};
      else
        merge = {data[7:0], cur[7:0]};
    end
  endfunction

  // Address decode for option one, word or either byte
  function sel_one;
    input       i2c;
    input [7:0] addr;
    begin
      if (i2c)
        sel_one = (addr == `COR_I2C_OPT_ONE_LO) ||
                  (addr == `COR_I2C_OPT_ONE_HI);
      else
        sel_one = (addr == `COR_SMB_CMD_OPT_ONE);
    end
  endfunction

  // Address decode for option two
  function sel_two;
    input       i2c;
    input [7:0] addr;
    begin
      if (i2c)
        sel_two = (addr == `COR_I2C_OPT_TWO_LO);
      else
        sel_two = (addr == `COR_SMB_CMD_OPT_TWO);
    end
  endfunction

  // One-cycle millisecond tick from the free-running divider
  assign ms_tick = (ms_div_q == MS_CYCLES - 1);
  assign one_hit = wr_en && sel_one(i2c_mode, wr_addr);
  assign two_hit = wr_en && sel_two(i2c_mode, wr_addr);
  assign one_wr = merge(i2c_mode, wr_addr, `COR_I2C_OPT_ONE_LO, opt_one_q,
    wr_data) & `COR_OPT_ONE_MASK;
  assign two_wr = {8'h00, wr_data[7:0]} & `COR_OPT_TWO_MASK;
  assign dis_done = ms_tick && dis_ms_q == `COR_DISCHARGE_MS - 1;
  assign wake_done = ms_tick && wake_ms_q == `COR_WAKE_MAX_MIN * 60000 - 1;
  assign recov_done = ms_tick && recov_ms_q == `COR_WAKE_DEG_MIN * 60000 - 1;

  // ****************************************************************
  // Option registers
  // ****************************************************************
  always @(posedge clock)
  begin
    if (reset)
    begin
      opt_one_q <= `COR_OPT_ONE_RESET;
      opt_two_q <= `COR_OPT_TWO_RESET;
    end
    else
    begin
      if (one_hit)
        opt_one_q <= one_wr;
      if (two_hit)
        opt_two_q <= two_wr;
      if (adapter_plugged)
        opt_one_q[`COR_BIT_FORCE_OFF] <= 1'b0;
      if (opt_one_q[`COR_BIT_DISCHARGE] && dis_done)
        opt_one_q[`COR_BIT_DISCHARGE] <= 1'b0;
      if (wake_state_q == ST_WAKE && wake_done)
        opt_one_q[`COR_BIT_WAKEUP] <= 1'b0;
    end
  end

  // ****************************************************************
  // Timers
  // ****************************************************************
  // Millisecond divider
  always @(posedge clock)
  begin
    if (reset || ms_tick)
    begin
      ms_div_q <= 32'h0000_0000;
    end
    else
    begin
      ms_div_q <= ms_div_q + 32'h0000_0001;
    end
  end

  // Discharge interval counter, idle while the bit is clear
  always @(posedge clock)
  begin
    if (reset || !opt_one_q[`COR_BIT_DISCHARGE] || dis_done)
    begin
      dis_ms_q <= 6'h00;
    end
    else if (ms_tick)
    begin
      dis_ms_q <= dis_ms_q + 6'h01;
    end
  end

  // ****************************************************************
  // Wake-up charge
  // ****************************************************************
  always @(posedge clock)
  begin
    if (reset)
    begin
      wake_state_q <= ST_IDLE;
      wake_ms_q <= 22'h000000;
      recov_ms_q <= 17'h00000;
      wakeup_charge_active <= 1'b0;
    end
    else
    begin
      case (wake_state_q)
        ST_IDLE:
        begin
          wake_ms_q <= 22'h000000;
          recov_ms_q <= 17'h00000;
          if (opt_one_q[`COR_BIT_WAKEUP] && battery_low)
          begin
            wake_state_q <= ST_WAKE;
            wakeup_charge_active <= 1'b1;
          end
        end
        ST_WAKE:
        begin
          if (ms_tick)
            wake_ms_q <= wake_ms_q + 22'h000001;
          if (battery_low)
            recov_ms_q <= 17'h00000;
          else if (ms_tick)
            recov_ms_q <= recov_ms_q + 17'h00001;
          if (wake_done || recov_done || !opt_one_q[`COR_BIT_WAKEUP])
          begin
            wake_state_q <= ST_IDLE;
            wakeup_charge_active <= 1'b0;
          end
        end
        default:
        begin
          wake_state_q <= ST_IDLE;
          wakeup_charge_active <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Power path latch-off
  // ****************************************************************
  // Sticky until power-on reset; host writes cannot clear it
  always @(posedge clock)
  begin
    if (reset)
    begin
      power_path_latched_off <= 1'b0;
    end
    else if (opt_one_q[`COR_BIT_LATCH_EN] && comparator_enable &&
             comparator_tripped)
    begin
      power_path_latched_off <= 1'b1;
    end
  end

  // ****************************************************************
  // Read back
  // ****************************************************************
  // Unknown addresses read as zero
  always @(posedge clock)
  begin
    if (reset)
    begin
      rd_data <= 16'h0000;
    end
    else if (!i2c_mode)
    begin
      case (rd_addr)
        `COR_SMB_CMD_OPT_ONE:
          rd_data <= opt_one_q;
        `COR_SMB_CMD_OPT_TWO:
          rd_data <= opt_two_q;
        default:
          rd_data <= 16'h0000;
      endcase
    end
    else
    begin
      case (rd_addr)
        `COR_I2C_OPT_ONE_LO:
          rd_data <= {8'h00, opt_one_q[7:0]};
        `COR_I2C_OPT_ONE_HI:
          rd_data <= {8'h00, opt_one_q[15:8]};
        `COR_I2C_OPT_TWO_LO:
          rd_data <= {8'h00, opt_two_q[7:0]};
        default:
          rd_data <= 16'h0000;
      endcase
    end
  end

  // ****************************************************************
  // Field outputs
  // ****************************************************************
  assign sense_resistor_ratio = opt_one_q[`COR_BIT_RATIO];
  assign battery_current_monitor_en =
    opt_one_q[`COR_BIT_BATTERY_CURRENT_MONITOR_EN];
  assign system_power_monitor_en =
    opt_one_q[`COR_BIT_SYSTEM_POWER_MONITOR_EN];
  assign system_power_monitor_gain =
    opt_one_q[`COR_BIT_SYSTEM_POWER_MONITOR_GAIN];
  assign comparator_reference_select =
    opt_one_q[`COR_BIT_COMPARATOR_REFERENCE_SELECT];
  assign comparator_output_polarity =
    opt_one_q[`COR_BIT_COMPARATOR_OUTPUT_POLARITY];
  assign comparator_deglitch_select =
    opt_one_q[`COR_BIT_DEG_HI:`COR_BIT_DEG_LO];
  assign comparator_enable = |comparator_deglitch_select;
  assign battery_switch_off = opt_one_q[`COR_BIT_FORCE_OFF];
  assign battery_pin_discharge = opt_one_q[`COR_BIT_DISCHARGE];
  assign charge_option_two_q = opt_two_q;
endmodule // cor_charge_option
`default_nettype wire

// File: core/cor_charge_option_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef COR_CHARGE_OPTION_REGS_VH
`define COR_CHARGE_OPTION_REGS_VH
// ****************************************************************
// Addresses
// ****************************************************************
`define COR_SMB_CMD_OPT_ONE     8'h3B
`define COR_SMB_CMD_OPT_TWO     8'h38
`define COR_I2C_OPT_ONE_LO      8'h02
`define COR_I2C_OPT_ONE_HI      8'h03
`define COR_I2C_OPT_TWO_LO      8'h10
// ****************************************************************
// Fields
// ****************************************************************
`define COR_BIT_RATIO           12
`define COR_BIT_BATTERY_CURRENT_MONITOR_EN         11
`define COR_BIT_SYSTEM_POWER_MONITOR_EN         10
`define COR_BIT_SYSTEM_POWER_MONITOR_GAIN       9
`define COR_BIT_COMPARATOR_REFERENCE_SELECT         7
`define COR_BIT_COMPARATOR_OUTPUT_POLARITY         6
`define COR_BIT_DEG_HI          5
`define COR_BIT_DEG_LO          4
`define COR_BIT_LATCH_EN        3
`define COR_BIT_FORCE_OFF       2
`define COR_BIT_DISCHARGE       1
`define COR_BIT_WAKEUP          0
`define COR_OPT_ONE_MASK        16'h1EFF
`define COR_OPT_TWO_MASK        16'h00C0
`define COR_OPT_ONE_RESET       16'h0211
`define COR_OPT_TWO_RESET       16'h0080
// ****************************************************************
// Timing (250 MHz clock, 4 ns)
// ****************************************************************
`define COR_CLK_PERIOD_NS       4
`define COR_MS_NS               1000000
`define COR_DISCHARGE_MS        40
`define COR_WAKE_MAX_MIN        30
`define COR_WAKE_DEG_MIN        1
`define COR_MS_CYCLES           (`COR_MS_NS / `COR_CLK_PERIOD_NS)
`endif

// File: test/cor_charge_option_props.sv
// Checker for the charge option register bank
`default_nettype none
module cor_charge_option_props #(
  parameter int MS_CYCLES = 250000
) (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        i2c_mode,
  input wire logic        wr_en,
  input wire logic [7:0]  wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] rd_data,
  input wire logic        adapter_plugged,
  input wire logic        battery_low,
  input wire logic        comparator_tripped,
  input wire logic        sense_resistor_ratio,
  input wire logic        comparator_reference_select,
  input wire logic [1:0]  comparator_deglitch_select,
  input wire logic        comparator_enable,
  input wire logic        power_path_latched_off,
  input wire logic        battery_switch_off,
  input wire logic        battery_pin_discharge,
  input wire logic        wakeup_charge_active
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic [31:0] dis_q;
  logic [63:0] wake_q;
  always @(posedge clock)
    dis_q <= (reset || !battery_pin_discharge) ? 32'h0 : dis_q + 32'h1;
  always @(posedge clock)
    wake_q <= (reset || !wakeup_charge_active) ? 64'h0 : wake_q + 64'h1;
  a_smb_write: assert property (
    !i2c_mode && wr_en && wr_addr == 8'h3B |=>
    sense_resistor_ratio == $past(wr_data[12]) &&
    comparator_reference_select == $past(wr_data[7])) else $error("word write");
  a_i2c_high: assert property (
    i2c_mode && wr_en && wr_addr == 8'h03 |=>
    sense_resistor_ratio == $past(wr_data[4])) else $error("high byte");
  a_i2c_low: assert property (
    i2c_mode && wr_en && wr_addr == 8'h02 |=>
    comparator_deglitch_select == $past(wr_data[5:4])) else $error("low byte");
  a_wake_limit: assert property (
    wake_q <= 64'h1B7740 * MS_CYCLES + 64'h2) else $error("wake too long");
  a_comp_enable: assert property (comparator_enable ==
    (comparator_deglitch_select != 2'h0)) else $error("comparator enable");
  a_latch_cause: assert property (
    $rose(power_path_latched_off) |->
    $past(comparator_tripped && comparator_enable)) else $error("latch cause");
  a_latch_hold: assert property (power_path_latched_off |=>
    power_path_latched_off) else $error("latch dropped");
  a_force_clear: assert property (adapter_plugged |=>
    !battery_switch_off) else $error("force off kept");
  a_reserved_zero: assert property (rd_data[15:13] == 3'h0 &&
    !rd_data[8]) else $error("reserved bit set");
  a_discharge_max: assert property (dis_q <= 40 * MS_CYCLES + 2)
    else $error("discharge too long");
  a_wake_cause: assert property ($rose(wakeup_charge_active) |->
    $past(battery_low)) else $error("wake without low battery");
  c_latch: cover property ($rose(power_path_latched_off));
  c_discharge: cover property ($fell(battery_pin_discharge));
  c_wake_end: cover property ($fell(wakeup_charge_active));
endmodule // cor_charge_option_props
bind cor_charge_option cor_charge_option_props #(.MS_CYCLES(MS_CYCLES))
  u_cor_charge_option_props (.clock(clock), .reset(reset),
  .i2c_mode(i2c_mode), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
  .rd_data(rd_data), .adapter_plugged(adapter_plugged),
  .battery_low(battery_low), .comparator_tripped(comparator_tripped),
  .sense_resistor_ratio(sense_resistor_ratio),
  .comparator_reference_select(comparator_reference_select),
  .comparator_deglitch_select(comparator_deglitch_select),
  .comparator_enable(comparator_enable),
  .power_path_latched_off(power_path_latched_off),
  .battery_switch_off(battery_switch_off),
  .battery_pin_discharge(battery_pin_discharge),
  .wakeup_charge_active(wakeup_charge_active));
`default_nettype wire

// File: test/cor_host_model.sv
// Host model driving the option register access port
`default_nettype none
module cor_host_model (
  input  wire logic        clock,
  output var  logic        i2c_mode,
  output var  logic        wr_en,
  output var  logic [7:0]  wr_addr,
  output var  logic [15:0] wr_data,
  output var  logic [7:0]  rd_addr,
  input  wire logic [15:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {i2c_mode, wr_en, wr_addr, wr_data, rd_addr} = '0;
  end
  task automatic wr_word(input logic i2c, input logic [7:0] a,
                         input logic [15:0] d);
    @(posedge clock);
    i2c_mode <= i2c;
    wr_en    <= 1'b1;
    wr_addr  <= a;
    wr_data  <= d;
    @(posedge clock);
    wr_en    <= 1'b0;
    wr_data  <= ~d;
  endtask
  task automatic rd_word(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    i2c_mode <= 1'b0;
    rd_addr  <= a;
    repeat (2) @(posedge clock);
    d = rd_data;
  endtask
endmodule // cor_host_model
`default_nettype wire

// File: test/tb_cor_charge_option.sv
// Testbench for the charge option register bank
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_cor_charge_option;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, reset = 1'b1, adapter = 1'b0, low = 1'b0, trip = 1'b0;
  wire i2c_mode, wr_en, latched, bsw_off, dis, wake, cen;
  wire [7:0] wr_addr, rd_addr, flds;
  wire [15:0] wr_data, rd_data, two_q;
  int failures = 0;
  int num_checks = 0;
  logic [15:0] v;
  always #2 clock = ~clock;
  cor_host_model u_cor_host_model (.clock(clock), .i2c_mode(i2c_mode),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data));
  cor_charge_option #(.MS_CYCLES(1)) u_cor_charge_option (.clock(clock),
    .reset(reset), .i2c_mode(i2c_mode), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
    .adapter_plugged(adapter), .battery_low(low), .comparator_tripped(trip),
    .sense_resistor_ratio(flds[7]), .battery_current_monitor_en(flds[6]),
    .system_power_monitor_en(flds[5]), .system_power_monitor_gain(flds[4]),
    .comparator_reference_select(flds[3]),
    .comparator_output_polarity(flds[2]),
    .comparator_deglitch_select(flds[1:0]), .comparator_enable(cen),
    .power_path_latched_off(latched), .battery_switch_off(bsw_off),
    .battery_pin_discharge(dis), .wakeup_charge_active(wake),
    .charge_option_two_q(two_q));
  task automatic finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #(4 * 90000);
    failures++;
    finish_test();
  end
  initial
  begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    u_cor_host_model.rd_word(8'h3B, v);
    `CHK("opt_one_reset", 16'h0211, v)
    `CHK("fields_reset", 8'h11, flds)
    u_cor_host_model.rd_word(8'h38, v);
    `CHK("opt_two_reset", 16'h0080, v)
    u_cor_host_model.wr_word(1'b0, 8'h38, 16'hFFFF);
    u_cor_host_model.rd_word(8'h38, v);
    `CHK("opt_two_mask", 16'h00C0, v)
    `CHK("opt_two_out", 16'h00C0, two_q)
    u_cor_host_model.wr_word(1'b0, 8'h3B, 16'h0008);
    trip <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK("latch_cmp_off", 1'b0, latched)
    u_cor_host_model.wr_word(1'b0, 8'h3B, 16'hFFFF);
    repeat (3) @(posedge clock);
    `CHK("latch_on", 1'b1, latched)
    `CHK("switch_off", 1'b1, bsw_off)
    `CHK("discharge_on", 1'b1, dis)
    `CHK("fields_set", 8'hFF, flds)
    `CHK("cmp_enable", 1'b1, cen)
    trip <= 1'b0;
    u_cor_host_model.rd_word(8'h3B, v);
    `CHK("opt_one_full", 16'h1EFF, v)
    adapter <= 1'b1;
    repeat (2) @(posedge clock);
    adapter <= 1'b0;
    `CHK("switch_freed", 1'b0, bsw_off)
    repeat (40) @(posedge clock);
    u_cor_host_model.rd_word(8'h3B, v);
    `CHK("self_cleared", 16'h1EF9, v)
    `CHK("latch_held", 1'b1, latched)
    u_cor_host_model.wr_word(1'b1, 8'h02, 16'h0024);
    u_cor_host_model.wr_word(1'b1, 8'h03, 16'h0002);
    u_cor_host_model.rd_word(8'h3B, v);
    `CHK("byte_writes", 16'h0224, v)
    `CHK("fields_bytes", 8'h12, flds)
    u_cor_host_model.wr_word(1'b1, 8'h10, 16'h0040);
    u_cor_host_model.rd_word(8'h38, v);
    `CHK("opt_two_byte", 16'h0040, v)
    reset <= 1'b1;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    `CHK("latch_reset", 1'b0, latched)
    low <= 1'b1;
    repeat (4) @(posedge clock);
    `CHK("wake_on", 1'b1, wake)
    low <= 1'b0;
    repeat (30000) @(posedge clock);
    `CHK("wake_kept", 1'b1, wake)
    repeat (30100) @(posedge clock);
    `CHK("wake_done", 1'b0, wake)
    finish_test();
  end
endmodule // tb_cor_charge_option
`default_nettype wire
